/* core/sfs_map.vh */
/*
 constants for the serial flash front end: opcodes, status bit positions,
 power-up values, erase geometry and register byte offsets.
 assumes it is included by the design files by bare name.
*/
`ifndef SFS_MAP_VH
`define SFS_MAP_VH

// opcodes
`define SFS_OP_WRITE_STATUS_CMD    8'h01
`define SFS_OP_READ    8'h03
`define SFS_OP_WRDI    8'h04
`define SFS_OP_RDSR    8'h05
`define SFS_OP_WREN    8'h06
`define SFS_OP_RDSR1   8'h35
`define SFS_OP_AAI     8'hAD
`define SFS_OP_SE4K    8'h20
`define SFS_OP_BE32K   8'h52
`define SFS_OP_BE64K   8'hD8

// frame byte counts needed before commit, and the byte counter ceiling
`define SFS_N_WRITE_STATUS_CMD     3'h2
`define SFS_N_WRSR1    3'h3
`define SFS_N_ADDR     3'h4
`define SFS_N_AAI      3'h6
`define SFS_N_MAX      3'h7

// status byte bit positions
`define SFS_ST_BUSY    0
`define SFS_ST_WEL     1
`define SFS_ST_BP0     2
`define SFS_ST_BP1     3
`define SFS_ST_AAI     6
`define SFS_ST_BPL     7
// status byte 1 bit positions
`define SFS_ST1_TSP    2
`define SFS_ST1_BSP    3

// power-up values
`define SFS_RST_BP     1'h1
`define SFS_RST_BPL    1'h0
`define SFS_RST_SECT   1'h0

// erase geometry as address shifts: 4 KByte, 32 KByte, 64 KByte
`define SFS_SH_4K      5'h0C
`define SFS_SH_32K     5'h0F
`define SFS_SH_64K     5'h10
`define SFS_EK_NONE    2'h0
`define SFS_EK_4K      2'h1
`define SFS_EK_32K     2'h2
`define SFS_EK_64K     2'h3

// register byte offsets
`define SFS_REG_CTRL   8'h00
`define SFS_REG_STAT   8'h04
`define SFS_REG_EVT    8'h08
`define SFS_REG_ERASE  8'h0C
`define SFS_REG_RX     8'h10
`define SFS_REG_TX     8'h14

// control and event bits
`define SFS_CT_BUSY    0
`define SFS_CT_RBEN    1
`define SFS_EV_ERASE   0
`define SFS_EV_REJ     1
`define SFS_EV_WRITE_STATUS_CMD    2

`endif

/* core/sfs_sync.v */
/*
 two-flop synchroniser for a group of pin levels.
 assumes inputs are asynchronous levels; first stage feeds only the second.
*/
`timescale 1ns/10ps
`default_nettype none

module sfs_sync #(
   parameter W = 5
) (
   // clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // levels
   input  wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // reset to all ones: the pins idle high
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= {W{1'b1}};
         sync_q <= {W{1'b1}};
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule

`default_nettype wire

/* core/sfs_shift.v */
/*
 serial byte engine: shifts in on sample strobes, shifts out on drive strobes.
 assumes strobes are single-cycle pulses in the hclk domain, already gated by hold.
*/
`timescale 1ns/10ps
`default_nettype none

module sfs_shift #(
   parameter W  = 8,
   parameter CW = 3
) (
   // clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // control
   input  wire         clr,
   input  wire         smp,
   input  wire         shf,
   input  wire         sdi,
   input  wire         ld,
   input  wire [W-1:0] ld_data,
   // results
   output reg  [W-1:0] rx_q,
   output reg          done_q,
   output reg          sdo_q
);

   localparam integer  LASTI = W - 1;
   localparam [CW-1:0] LAST  = LASTI[CW-1:0];

   reg [CW-1:0] bitc_q;
   reg [W-1:0]  in_q;
   reg [W-1:0]  out_q;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bitc_q <= {CW{1'b0}};
         in_q   <= {W{1'b0}};
         out_q  <= {W{1'b0}};
         rx_q   <= {W{1'b0}};
         done_q <= 1'b0;
         sdo_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (clr) begin
            // new frame: bit position restarts, stale output dropped
            bitc_q <= {CW{1'b0}};
            out_q  <= {W{1'b0}};
         end else begin
            if (smp) begin
               in_q   <= {in_q[W-2:0], sdi};
               bitc_q <= (bitc_q == LAST) ? {CW{1'b0}} : bitc_q + 1'b1;
               if (bitc_q == LAST) begin
                  rx_q   <= {in_q[W-2:0], sdi};
                  done_q <= 1'b1;
               end
            end
            if (ld) begin
               out_q <= ld_data;
            end else if (shf) begin
               sdo_q <= out_q[W-1];
               out_q <= {out_q[W-2:0], 1'b0};
            end
         end
      end
   end

endmodule

`default_nettype wire

/* core/sfs_front.v */
/*
 spi target front end of a serial flash with hold, write protect and lock-down,
 plus an ahb-lite register slave for the array-side software.
 assumes pins arrive asynchronous to hclk and sck is well below hclk/8.
*/
//
// Function
// - serial input is sampled on each rising edge of the serial clock while selected and not in hold.
// - the serial output changes only after falling edges, one bit per edge.
// - during auto-increment programming the output line may show ready/busy instead of data.
// - spi modes 0 and 3 both work, with the same sampling and driving edges.
// - erase addresses are decoded into 4 KByte sectors and 32 or 64 KByte blocks.
// - hold begins when hold is low during a clock-low phase, at once or at the next one.
// - hold ends when hold is high during a clock-low phase, at once or at the next one.
// - in hold the output floats and clock and input levels are ignored.
// - hold freezes the transfer without losing the bit position.
// - select rising in hold abandons the transfer, hold stays while the hold pin is low.
// - a write-status command is refused when write protect is low and lock-down is set.
// - while locked, lock-down, block protect and sector protect bits cannot change.
// - at power-up the lock-down bit is cleared.
`timescale 1ns/10ps
`default_nettype none
`include "sfs_map.vh"

module sfs_front (
   // clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   // spi pins
   input  wire        sck,
   input  wire        ce_n,
   input  wire        si,
   input  wire        hold_n,
   input  wire        wp_n,
   output reg         so_o,
   output reg         so_oe
);

   // pin synchronisation
   wire [4:0] pins_s;
   wire       sck_s;
   wire       ce_n_s;
   wire       si_s;
   wire       hold_n_s;
   wire       wp_n_s;

   sfs_sync #(
      .W       (5)
   ) u_sync (
      .clk     (hclk),
      .rst_n   (hresetn),
      .async_i ({sck, ce_n, si, hold_n, wp_n}),
      .sync_o  (pins_s)
   );

   assign sck_s    = pins_s[4];
   assign ce_n_s   = pins_s[3];
   assign si_s     = pins_s[2];
   assign hold_n_s = pins_s[1];
   assign wp_n_s   = pins_s[0];

   // edge detection on synchronised levels
   reg  sck_d_q;
   reg  ce_n_d_q;
   reg  hold_q;
   wire sel      = ~ce_n_s;
   wire ce_fall  = ~ce_n_s & ce_n_d_q;
   wire ce_rise  = ce_n_s & ~ce_n_d_q;
   wire sck_rise = sck_s & ~sck_d_q & sel & ~hold_q;
   wire sck_fall = ~sck_s & sck_d_q & sel & ~hold_q;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sck_d_q  <= 1'b0;
         ce_n_d_q <= 1'b1;
      end else begin
         // idle level of sck is not assumed, so mode 0 and mode 3 look alike
         sck_d_q  <= sck_s;
         ce_n_d_q <= ce_n_s;
      end
   end

   // hold state, judged only in clock-low phases
   reg hold_d;
   always @* begin
      hold_d = hold_q;
      if (!hold_q) begin
         if (sel && !hold_n_s && !sck_s) begin
            hold_d = 1'b1;
         end
      end else if (hold_n_s && !sck_s) begin
         hold_d = 1'b0;
      end
   end

   // hold stays up across deselect while the pin is low
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_q <= 1'b0;
      end else begin
         hold_q <= hold_d;
      end
   end

   // software-visible state
   reg  [1:0]  ctrl_q;
   reg  [7:0]  tx_q;
   reg  [2:0]  evt_q;
   reg  [1:0]  ek_q;
   reg  [23:0] ebase_q;
   wire        busy = ctrl_q[`SFS_CT_BUSY];

   // device status state
   reg bp0_q;
   reg bp1_q;
   reg bpl_q;
   reg tsp_q;
   reg bsp_q;
   reg wel_q;
   reg aai_q;

   wire [7:0] stat0 = {bpl_q, aai_q, 2'h0, bp1_q, bp0_q, wel_q, busy};
   wire [7:0] stat1 = {4'h0, bsp_q, tsp_q, 2'h0};

   // frame tracking
   wire [7:0]  rx_byte;
   wire        byte_done;
   wire        sdo;
   reg  [2:0]  bcnt_q;
   reg  [7:0]  op_q;
   reg  [23:0] addr_q;
   reg  [7:0]  d1_q;
   reg  [7:0]  d2_q;
   reg         drive_q;

   // opcode in force, including the byte that just completed
   wire [7:0] cmd_now  = (bcnt_q == 3'h0) ? rx_byte : op_q;
   reg  [7:0] tx_next;
   reg        tx_rd;

   always @* begin
      tx_next = 8'h00;
      tx_rd   = 1'b0;
      case (cmd_now)
         `SFS_OP_RDSR: begin
            tx_next = stat0;
            tx_rd   = 1'b1;
         end
         `SFS_OP_RDSR1: begin
            tx_next = stat1;
            tx_rd   = 1'b1;
         end
         `SFS_OP_READ: begin
            tx_next = tx_q;
            tx_rd   = (bcnt_q >= 3'h3);
         end
         default: begin
            tx_next = 8'h00;
            tx_rd   = 1'b0;
         end
      endcase
   end

   sfs_shift #(
      .W       (8),
      .CW      (3)
   ) u_shift (
      .clk     (hclk),
      .rst_n   (hresetn),
      .clr     (ce_fall),
      .smp     (sck_rise),
      .shf     (sck_fall),
      .sdi     (si_s),
      .ld      (byte_done),
      .ld_data (tx_next),
      .rx_q    (rx_byte),
      .done_q  (byte_done),
      .sdo_q   (sdo)
   );

   // bit position lives in the shift engine and is untouched by hold
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bcnt_q  <= 3'h0;
         op_q    <= 8'h00;
         addr_q  <= 24'h000000;
         d1_q    <= 8'h00;
         d2_q    <= 8'h00;
         drive_q <= 1'b0;
      end else if (ce_fall) begin
         bcnt_q  <= 3'h0;
         drive_q <= 1'b0;
      end else if (byte_done) begin
         if (bcnt_q != `SFS_N_MAX) begin
            bcnt_q <= bcnt_q + 3'h1;
         end
         if (bcnt_q == 3'h0) begin
            op_q <= rx_byte;
         end
         if (bcnt_q >= 3'h1 && bcnt_q <= 3'h3) begin
            addr_q <= {addr_q[15:0], rx_byte};
         end
         if (bcnt_q == 3'h1) begin
            d1_q <= rx_byte;
         end
         if (bcnt_q == 3'h2) begin
            d2_q <= rx_byte;
         end
         drive_q <= tx_rd;
      end
   end

   // commit only a whole command, and never one cut off in hold
   wire commit = ce_rise & ~hold_q;
   wire locked = ~wp_n_s & bpl_q;

   // base address aligned to the erase unit
   function [23:0] align;
      input [23:0] a;
      input [4:0]  sh;
      begin
         align = (a >> sh) << sh;
      end
   endfunction

   // ahb-lite address phase
   reg        ph_wr_q;
   reg  [7:0] ph_addr_q;
   wire       ap  = hsel & hready & htrans[1];
   wire       evw = ph_wr_q && (ph_addr_q == `SFS_REG_EVT);
   wire [2:0] evclr = evw ? hwdata[2:0] : 3'h0;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bp0_q   <= `SFS_RST_BP;
         bp1_q   <= `SFS_RST_BP;
         bpl_q   <= `SFS_RST_BPL;
         tsp_q   <= `SFS_RST_SECT;
         bsp_q   <= `SFS_RST_SECT;
         wel_q   <= 1'b0;
         aai_q   <= 1'b0;
         evt_q   <= 3'h0;
         ek_q    <= `SFS_EK_NONE;
         ebase_q <= 24'h000000;
      end else begin
         // set wins over a software clear in the same cycle
         evt_q <= evt_q & ~evclr;
         if (commit) begin
            case (op_q)
               `SFS_OP_WREN: begin
                  if (bcnt_q == 3'h1) begin
                     wel_q <= 1'b1;
                  end
               end
               `SFS_OP_WRDI: begin
                  if (bcnt_q == 3'h1) begin
                     wel_q <= 1'b0;
                     aai_q <= 1'b0;
                  end
               end
               `SFS_OP_WRITE_STATUS_CMD: begin
                  if (bcnt_q >= `SFS_N_WRITE_STATUS_CMD) begin
                     if (locked) begin
                        // nothing protected may move while locked
                        evt_q[`SFS_EV_REJ] <= 1'b1;
                     end else begin
                        bp0_q <= d1_q[`SFS_ST_BP0];
                        bp1_q <= d1_q[`SFS_ST_BP1];
                        bpl_q <= d1_q[`SFS_ST_BPL];
                        if (bcnt_q >= `SFS_N_WRSR1) begin
                           tsp_q <= d2_q[`SFS_ST1_TSP];
                           bsp_q <= d2_q[`SFS_ST1_BSP];
                        end
                        wel_q <= 1'b0;
                        evt_q[`SFS_EV_WRITE_STATUS_CMD] <= 1'b1;
                     end
                  end
               end
               `SFS_OP_AAI: begin
                  if (bcnt_q >= `SFS_N_AAI) begin
                     aai_q <= 1'b1;
                  end
               end
               `SFS_OP_SE4K: begin
                  if (bcnt_q >= `SFS_N_ADDR) begin
                     ek_q    <= `SFS_EK_4K;
                     ebase_q <= align(addr_q, `SFS_SH_4K);
                     evt_q[`SFS_EV_ERASE] <= 1'b1;
                  end
               end
               `SFS_OP_BE32K: begin
                  if (bcnt_q >= `SFS_N_ADDR) begin
                     ek_q    <= `SFS_EK_32K;
                     ebase_q <= align(addr_q, `SFS_SH_32K);
                     evt_q[`SFS_EV_ERASE] <= 1'b1;
                  end
               end
               `SFS_OP_BE64K: begin
                  if (bcnt_q >= `SFS_N_ADDR) begin
                     ek_q    <= `SFS_EK_64K;
                     ebase_q <= align(addr_q, `SFS_SH_64K);
                     evt_q[`SFS_EV_ERASE] <= 1'b1;
                  end
               end
               default: begin
                  wel_q <= wel_q;
               end
            endcase
         end
      end
   end

   // output pin: data, or ready/busy in auto-increment mode when ctrl_q[SFS_CT_RBEN] is set
   wire rb_mode = aai_q & ctrl_q[`SFS_CT_RBEN];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         so_o  <= 1'b0;
         so_oe <= 1'b0;
      end else begin
         // four hclk behind the pin falling edge (two sync stages, the shift flop, this flop), inside the low phase
         so_o  <= rb_mode ? ~busy : sdo;
         so_oe <= sel & ~hold_q & (drive_q | rb_mode);
      end
   end

   // ahb-lite slave: zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   reg [31:0] rd_d;
   always @* begin
      rd_d = 32'h00000000;
      case (haddr)
         `SFS_REG_CTRL:  rd_d = {30'h0, ctrl_q};
         `SFS_REG_STAT:  rd_d = {16'h0, stat1, stat0};
         `SFS_REG_EVT:   rd_d = {29'h0, evt_q};
         `SFS_REG_ERASE: rd_d = {6'h0, ek_q, ebase_q};
         `SFS_REG_RX:    rd_d = {24'h0, rx_byte};
         `SFS_REG_TX:    rd_d = {24'h0, tx_q};
         default:        rd_d = 32'h00000000;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr_q   <= 1'b0;
         ph_addr_q <= 8'h00;
         hrdata    <= 32'h00000000;
         ctrl_q    <= 2'h0;
         tx_q      <= 8'h00;
      end else begin
         ph_wr_q <= ap & hwrite;
         if (ap) begin
            ph_addr_q <= haddr;
         end
         if (ap && !hwrite) begin
            hrdata <= rd_d;
         end
         if (ph_wr_q && ph_addr_q == `SFS_REG_CTRL) begin
            ctrl_q <= hwdata[1:0];
         end
         if (ph_wr_q && ph_addr_q == `SFS_REG_TX) begin
            tx_q <= hwdata[7:0];
         end
      end
   end

endmodule

`default_nettype wire

/* verification/sfs_front_props.sv */
/*
 concurrent checks on the ports of sfs_front.
 assumes a bind from the bench top; one hclk domain, reset hresetn.
*/
`timescale 1ns/10ps
`default_nettype none
module sfs_front_props (
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // ahb-lite
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // spi pins
   input wire logic        sck,
   input wire logic        ce_n,
   input wire logic        si,
   input wire logic        hold_n,
   input wire logic        wp_n,
   input wire logic        so_o,
   input wire logic        so_oe
);
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   wire logic rd_take;
   logic      seen_q;
   assign rd_take = hsel && hready && htrans[1] && !hwrite;
   // power-up values only hold until a frame may change them
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seen_q <= 1'b0;
      end else if (!ce_n) begin
         seen_q <= 1'b1;
      end
   end
   a_oe_deselect: assert property (ce_n [*8] |-> !so_oe)
      else $error("serial output driven while deselected");
   a_hold_float: assert property ((!hold_n && !sck) [*8] |-> !so_oe)
      else $error("serial output driven in hold");
   a_so_fall_only: assert property ((sck && so_oe) [*8] |-> $stable(so_o))
      else $error("serial output moved while clock high");
   a_stat_powerup: assert property (rd_take && haddr == 8'h04 && !seen_q |=> hrdata == 32'hC)
      else $error("status after reset wrong");
   a_stat_reserved: assert property (rd_take && haddr == 8'h04 |=> (hrdata & 32'hFFFFF330) == 32'h0)
      else $error("reserved status bits set");
   a_unmapped_zero: assert property (rd_take && haddr >= 8'h18 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_rdata_stands: assert property (!rd_take |=> $stable(hrdata))
      else $error("read data moved without a read");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or error response");
endmodule
`default_nettype wire

/* verification/sfs_spi_host.sv */
/*
 spi master model driving the flash front end pins.
 assumes the bench clock hclk; half an sck period is 8 hclk (64 ns period).
*/
`timescale 1ns/10ps
`default_nettype none
module sfs_spi_host (
   // clock
   input  wire logic hclk,
   // pins
   output var  logic sck,
   output var  logic ce_n,
   output var  logic si,
   output var  logic hold_n,
   input  wire logic so
);
   logic       mode3 = 1'b0;
   logic [7:0] rx    = 8'h00;
   initial begin
      sck    = 1'b0;
      ce_n   = 1'b1;
      si     = 1'b0;
      hold_n = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // idle level of sck picks the mode, changed between frames only
   task automatic set_mode(input logic m);
      mode3 = m;
      sck  <= m;
      tick(8);
   endtask
   // select falls first and stays low to the end
   task automatic sel;
      ce_n <= 1'b0;
      tick(8);
   endtask
   task automatic unsel;
      sck  <= mode3;
      tick(8);
      ce_n <= 1'b1;
      si   <= ~si; // released line flips, so no stale bit looks valid
      tick(8);
   endtask
   // msb first; so is taken just before each rise
   task automatic bits(input int n, input logic [7:0] d);
      for (int i = 0; i < n; i++) begin
         sck <= 1'b0;
         si  <= d[7-i];
         tick(8);
         rx   = {rx[6:0], so};
         sck <= 1'b1;
         tick(8);
      end
   endtask
   task automatic frame(input int n, input logic [47:0] d, input logic close);
      sel;
      for (int k = n - 1; k >= 0; k--) bits(8, d[8*k +: 8]);
      if (close) unsel;
   endtask
   task automatic park;
      sck <= 1'b0;
      tick(8);
   endtask
   // hold moves with sck low, while selected or after deselect
   task automatic hold(input logic v);
      hold_n <= v;
      tick(16);
   endtask
endmodule
`default_nettype wire

/* verification/tb.sv */
/*
 self-checking bench for the flash front end: ahb tasks, spi host model.
 assumes sfs_front, sfs_spi_host and sfs_front_props are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        hclk = 1'b0;
   logic        hresetn;
   logic        hsel;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [2:0]  hsize;
   logic        wp_n;
   logic        so_last = 1'b0;
   logic [7:0]  t;
   wire  logic  hreadyout, hresp, so_o, so_oe, sck, ce_n, si, hold_n, so_pin;
   wire  logic [31:0] hrdata;
   int          num_errors = 0;
   int          comparisons = 0;
   logic [7:0]  eop [3] = '{8'h20, 8'h52, 8'hD8};
   logic [31:0] eexp [3] = '{32'h0101A000, 32'h02018000, 32'h03010000};
   always #2 hclk = ~hclk;
   // a floating output reads as the inverse of its last bit
   always @(posedge hclk)
      if (so_oe) so_last <= so_o;
   assign so_pin = so_oe ? so_o : ~so_last;
   sfs_front u_sfs_front (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .sck(sck), .ce_n(ce_n), .si(si), .hold_n(hold_n), .wp_n(wp_n),
      .so_o(so_o), .so_oe(so_oe));
   sfs_spi_host u_host (.hclk(hclk), .sck(sck), .ce_n(ce_n), .si(si), .hold_n(hold_n), .so(so_pin));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      hsize  <= 3'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      ahb(1'b0, a, 32'h0, d);
      chk(d, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask
   task automatic sread(input int n, input logic [47:0] d, input logic [7:0] e);
      u_host.frame(n, d, 1'b0);
      u_host.bits(8, 8'h00);
      u_host.unsel;
      chk({24'h0, u_host.rx}, {24'h0, e});
   endtask
   task automatic print_verdict;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #300000;
      num_errors++;
      print_verdict;
   end
   initial begin
      hresetn = 1'b0;
      hsel    = 1'b0;
      haddr   = 8'h00;
      htrans  = 2'h0;
      hwrite  = 1'b0;
      hwdata  = 32'h0;
      hsize   = 3'h0;
      wp_n    = 1'b1;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (8) @(posedge hclk);
      rd(8'h04, 32'hC);
      rd(8'h20, 32'h0);
      for (int m = 0; m < 2; m++) begin
         u_host.set_mode(m == 1);
         sread(1, 48'h05, 8'h0C);
         sread(1, 48'h35, 8'h00);
      end
      u_host.set_mode(1'b0);
      wr(8'h14, 32'hA5);
      sread(4, 48'h03000010, 8'hA5);
      // lock, clear block bits, set both sector locks
      u_host.frame(3, 48'h01800C, 1'b1);
      rd(8'h04, 32'hC80);
      wp_n <= 1'b0;
      u_host.frame(3, 48'h010C00, 1'b1);
      rd(8'h04, 32'hC80);
      rd(8'h08, 32'h6);
      // write one clears the event bits
      wr(8'h08, 32'h6);
      rd(8'h08, 32'h0);
      wp_n <= 1'b1;
      u_host.frame(3, 48'h010000, 1'b1);
      rd(8'h04, 32'h0);
      wp_n <= 1'b0;
      u_host.frame(2, 48'h010C, 1'b1);
      rd(8'h04, 32'hC);
      // four stray data bits must not commit a zero status
      u_host.frame(1, 48'h01, 1'b0);
      u_host.bits(4, 8'h00);
      u_host.unsel;
      rd(8'h04, 32'hC);
      u_host.frame(1, 48'h05, 1'b0);
      u_host.bits(3, 8'h00);
      t = u_host.rx;
      u_host.park;
      u_host.hold(1'b0);
      chk({31'h0, so_oe}, 32'h0);
      u_host.bits(2, 8'hFF);
      u_host.park;
      u_host.hold(1'b1);
      u_host.bits(5, 8'h00);
      chk({24'h0, t[2:0], u_host.rx[4:0]}, 32'hC);
      u_host.unsel;
      u_host.frame(2, 48'h0100, 1'b0);
      u_host.park;
      u_host.hold(1'b0);
      u_host.unsel;
      u_host.hold(1'b1);
      rd(8'h04, 32'hC);
      u_host.frame(2, 48'h0100, 1'b1);
      rd(8'h04, 32'h0);
      for (int k = 0; k < 3; k++) begin
         u_host.frame(1, 48'h06, 1'b1);
         u_host.frame(4, {16'h0, eop[k], 24'h01ABCD}, 1'b1);
         rd(8'h0C, eexp[k]);
      end
      u_host.frame(1, 48'h06, 1'b1);
      u_host.frame(6, 48'hAD0000001234, 1'b1);
      wr(8'h00, 32'h3);
      rd(8'h00, 32'h3);
      u_host.sel;
      chk({30'h0, so_oe, so_o}, 32'h2);
      wr(8'h00, 32'h2);
      u_host.tick(8);
      chk({30'h0, so_oe, so_o}, 32'h3);
      u_host.unsel;
      u_host.frame(1, 48'h04, 1'b1);
      print_verdict;
   end
endmodule
bind sfs_front sfs_front_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sck(sck), .ce_n(ce_n), .si(si),
   .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe));
`default_nettype wire
